// [aux_line_port.v]
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "aux_line_port_consts.vh"

module aux_line_port #(
  parameter LINES = 8
) (
  input wire mclk_in,
  input wire sys_rst_in,
  input wire power_on_rst_in,
  input wire sleep_retention_strap_in,
  input wire [3:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  output reg [7:0] reg_rdata_out,
  input wire [LINES-1:0] line_pin_in,
  output reg [LINES-1:0] line_pin_out,
  output reg [LINES-1:0] line_pin_oe_out,
  output reg irq_out
);

  reg [LINES-1:0] direction_reg;
  reg [LINES-1:0] invert_reg;
  reg [LINES-1:0] output_value_reg;
  reg [LINES-1:0] irq_enable_reg;
  reg [LINES-1:0] irq_flags_reg;
  reg [LINES-1:0] sync1_reg;
  reg [LINES-1:0] sync2_reg;
  reg [LINES-1:0] sync3_reg;
  reg [LINES-1:0] pin_level_reg;
  reg [LINES-1:0] pin_level_next;
  reg [LINES-1:0] edge_hit;
  reg [LINES-1:0] irq_flags_next;
  reg [7:0] rdata_next;
  reg strap_reg;
  reg config_clear;
  reg write_dir;
  reg write_inv;
  reg write_out;
  reg write_en;
  reg write_flags;
  genvar i;

  // strap is caught by a clocked process so the reset itself stays constant
  always @(posedge mclk_in) begin
    strap_reg <= sleep_retention_strap_in;
  end

  always @* begin
    config_clear = power_on_rst_in | (sys_rst_in & ~strap_reg);
    write_dir = reg_write_in & (reg_addr_in == `AUX_LINE_DIRECTION_OFFSET);
    write_inv = reg_write_in & (reg_addr_in == `AUX_LINE_INVERT_OFFSET);
    write_out = reg_write_in & (reg_addr_in == `AUX_LINE_OUTPUT_VALUE_OFFSET);
    write_en = reg_write_in & (reg_addr_in == `AUX_LINE_IRQ_ENABLE_OFFSET);
    write_flags = reg_write_in & (reg_addr_in == `AUX_LINE_IRQ_FLAGS_OFFSET);
  end

  // retained configuration
  always @(posedge mclk_in) begin
    if (config_clear) begin
      direction_reg <= `AUX_LINE_DIRECTION_RESET;
      invert_reg <= `AUX_LINE_INVERT_RESET;
      output_value_reg <= `AUX_LINE_OUTPUT_VALUE_RESET;
    end else begin
      if (write_dir) begin
        direction_reg <= reg_wdata_in[LINES-1:0];
      end
      if (write_inv) begin
        invert_reg <= reg_wdata_in[LINES-1:0];
      end
      if (write_out) begin
        output_value_reg <= reg_wdata_in[LINES-1:0];
      end
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in | power_on_rst_in) begin
      irq_enable_reg <= `AUX_LINE_IRQ_ENABLE_RESET;
    end else if (write_en) begin
      irq_enable_reg <= reg_wdata_in[LINES-1:0];
    end
  end

  // one generate slice per line; bit i is line i+1
  generate
    for (i = 0; i < LINES; i = i + 1) begin : g_line
      always @* begin
        // a change counts only once the second and third stages agree
        pin_level_next[i] = (sync2_reg[i] == sync3_reg[i]) ?
          (sync3_reg[i] ^ invert_reg[i]) : pin_level_reg[i];
        // asserted-going edge: rising uninverted, falling inverted
        edge_hit[i] = pin_level_next[i] & ~pin_level_reg[i];
        irq_flags_next[i] = edge_hit[i] |
          (irq_flags_reg[i] & ~(write_flags & reg_wdata_in[i]));
      end
    end
  endgenerate

  always @(posedge mclk_in) begin
    sync1_reg <= line_pin_in;
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in | power_on_rst_in) begin
      pin_level_reg <= {LINES{1'b0}};
      irq_flags_reg <= `AUX_LINE_IRQ_FLAGS_RESET;
    end else begin
      pin_level_reg <= pin_level_next;
      irq_flags_reg <= irq_flags_next;
    end
  end

  always @* begin
    rdata_next = `AUX_LINE_UNMAPPED_READ;
    case (reg_addr_in)
      `AUX_LINE_DIRECTION_OFFSET: rdata_next[LINES-1:0] = direction_reg;
      `AUX_LINE_INVERT_OFFSET: rdata_next[LINES-1:0] = invert_reg;
      `AUX_LINE_OUTPUT_VALUE_OFFSET: rdata_next[LINES-1:0] = output_value_reg;
      `AUX_LINE_PIN_LEVEL_OFFSET: rdata_next[LINES-1:0] = pin_level_reg;
      `AUX_LINE_IRQ_ENABLE_OFFSET: rdata_next[LINES-1:0] = irq_enable_reg;
      `AUX_LINE_IRQ_FLAGS_OFFSET: rdata_next[LINES-1:0] = irq_flags_reg;
      default: rdata_next = `AUX_LINE_UNMAPPED_READ;
    endcase
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in | power_on_rst_in) begin
      reg_rdata_out <= 8'h00;
      irq_out <= 1'b0;
    end else begin
      reg_rdata_out <= reg_read_in ? rdata_next : 8'h00;
      irq_out <= |(irq_flags_next & irq_enable_reg);
    end
  end

  // pins follow config one cycle later; outputs come from flops
  always @(posedge mclk_in) begin
    if (config_clear) begin
      line_pin_out <= {LINES{1'b0}};
      line_pin_oe_out <= {LINES{1'b0}};
    end else begin
      line_pin_out <= output_value_reg ^ invert_reg;
      line_pin_oe_out <= direction_reg;
    end
  end

endmodule // aux_line_port

// [aux_line_port_consts.vh]
`ifndef AUX_LINE_PORT_CONSTS_VH
`define AUX_LINE_PORT_CONSTS_VH

// register offsets on the plain register port
`define AUX_LINE_DIRECTION_OFFSET 4'h0
`define AUX_LINE_INVERT_OFFSET 4'h1
`define AUX_LINE_OUTPUT_VALUE_OFFSET 4'h2
`define AUX_LINE_PIN_LEVEL_OFFSET 4'h3
`define AUX_LINE_IRQ_ENABLE_OFFSET 4'h4
`define AUX_LINE_IRQ_FLAGS_OFFSET 4'h5

// reset values
`define AUX_LINE_DIRECTION_RESET 8'h00
`define AUX_LINE_INVERT_RESET 8'h00
`define AUX_LINE_OUTPUT_VALUE_RESET 8'h00
`define AUX_LINE_IRQ_ENABLE_RESET 8'h00
`define AUX_LINE_IRQ_FLAGS_RESET 8'h00
`define AUX_LINE_UNMAPPED_READ 8'h00

`endif

// [aux_line_port_chk.sv]
`timescale 1ns/1ps
module aux_line_port_chk #(parameter LINES = 8) (
  input wire mclk_in, input wire sys_rst_in, input wire power_on_rst_in,
  input wire sleep_retention_strap_in, input wire [3:0] reg_addr_in, input wire reg_read_in,
  input wire reg_write_in, input wire [7:0] reg_rdata_out, input wire [LINES-1:0] line_pin_in,
  input wire [LINES-1:0] line_pin_oe_out, input wire irq_out);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (power_on_rst_in);
  a_rd_idle: assert property (!reg_read_in |=> !reg_rdata_out) else $error("idle");
  a_unmapped_zero: assert property (
    reg_read_in && reg_addr_in > 4'h5 |=> !reg_rdata_out) else $error("unmapped");
  a_dir_readback: assert property (
    reg_read_in && reg_addr_in == 4'h0 |=> reg_rdata_out == line_pin_oe_out) else $error("dir");
  // irq_out only rises from a synchronised pin edge or a register write
  a_irq_cause: assert property ($rose(irq_out) |-> $past(reg_write_in) ||
    $past(reg_write_in, 2) || $past(line_pin_in, 2) != $past(line_pin_in, 6)) else $error("irq");
  a_rst_quiet: assert property (
    sys_rst_in |=> !irq_out && !reg_rdata_out) else $error("quiet");
  a_por_clears: assert property (disable iff (1'b0)
    power_on_rst_in |=> !line_pin_oe_out) else $error("por");
  a_strap_clear: assert property (
    sys_rst_in && !$past(sleep_retention_strap_in) |=> !line_pin_oe_out) else $error("clear");
  a_strap_keep: assert property (
    sys_rst_in && $past(sleep_retention_strap_in) |=> $stable(line_pin_oe_out)) else $error("keep");
  cover property ($rose(irq_out));
  cover property (sys_rst_in && sleep_retention_strap_in);
  cover property (reg_read_in && reg_addr_in == 4'h5);
endmodule // aux_line_port_chk
bind aux_line_port aux_line_port_chk #(.LINES(LINES)) i_chk (.*);

// [aux_line_far.sv]
`timescale 1ns/1ps
module aux_line_far (input wire [7:0] drv_in, input wire [7:0] oe_in, input wire [7:0] ext_in,
  output wire [7:0] pin_out);
  assign pin_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule // aux_line_far

// [aux_line_port_tb.sv]
`timescale 1ns/1ps
module aux_line_port_tb;
  logic clk = 0, rst = 1, por = 1, strap = 0, ws = 0, rs = 0, seen = 0, irq;
  logic [3:0] a = 0;
  logic [7:0] wd = 0, ext = 0, rdata, po, oe, pin, r, q, d, exp_q[$];
  int bad_count = 0, comparisons = 0, cyc = 0;
  always #12.5 clk = ~clk;
  aux_line_port i_dut (.mclk_in(clk), .sys_rst_in(rst), .power_on_rst_in(por),
    .sleep_retention_strap_in(strap), .reg_addr_in(a), .reg_wdata_in(wd), .reg_write_in(ws),
    .reg_read_in(rs), .reg_rdata_out(rdata), .line_pin_in(pin), .line_pin_out(po),
    .line_pin_oe_out(oe), .irq_out(irq));
  aux_line_far i_far (.drv_in(po), .oe_in(oe), .ext_in(ext), .pin_out(pin));
  task stop_test;
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] s, e);
    comparisons++;
    if (s !== e) bad_count++;
    if (s !== e) $display("Error %s expected %h seen %h", n, e, s);
  endtask
  // op is {write, address}; a read notes its expected byte first
  task bus(input logic [4:0] op, input logic [7:0] v);
    if (!op[4]) exp_q.push_back(v);
    @(posedge clk) {ws, a, rs, wd} <= {op, !op[4], v};
    @(posedge clk) {ws, rs} <= 2'b00;
  endtask
  task irq_is(input logic [7:0] e);
    repeat (6) @(posedge clk);
    #1 chk("irq", {7'h00, irq}, e);
  endtask
  always @(posedge clk) begin
    if (++cyc == 2000) bad_count++;
    if (cyc == 2000) stop_test;
    if (seen) chk("rdata", rdata, exp_q.pop_front());
    seen <= rs;
  end
  initial begin
    void'($urandom(32'h05DC));
    repeat (2) @(posedge clk);
    {rst, por} <= 2'b00;
    for (int i = 0; i < 8; i++) bus(5'(i), 8'h00);
    {r, q, d} = 24'($urandom);
    ext <= 8'($urandom);
    bus(5'h11, r);
    bus(5'h12, q);
    bus(5'h10, d);
    repeat (5) @(posedge clk);
    bus(5'h03, d & q | ~d & (ext ^ r));
    bus(5'h02, q);
    bus(5'h00, d);
    $display("register test done");
    bus(5'h10, 8'h00);
    bus(5'h11, 8'h00);
    ext <= 8'h00;
    repeat (5) @(posedge clk);
    bus(5'h15, 8'hFF);
    bus(5'h14, 8'h80);
    ext <= 8'h81;
    irq_is(8'h01);
    bus(5'h05, 8'h81);
    bus(5'h15, 8'h80);
    irq_is(8'h00);
    bus(5'h05, 8'h01);
    bus(5'h11, 8'h01);
    bus(5'h15, 8'hFF);
    bus(5'h14, 8'h01);
    ext <= 8'h80;
    irq_is(8'h01);
    $display("irq test done");
    strap <= 1'b1;
    bus(5'h10, 8'h5A);
    repeat (2) @(posedge clk);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    bus(5'h00, 8'h5A);
    bus(5'h04, 8'h00);
    strap <= 1'b0;
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    bus(5'h00, 8'h00);
    repeat (3) @(posedge clk);
    $display("retention test done");
    stop_test;
  end
endmodule // aux_line_port_tb
